/* core/serial_bus_arbiter_timer.v */
/*
 * Serial bus arbiter timer: 9-bit counter with overflow, three modes
 * (idle, bit time measurement, bus arbitration), APB register access and
 * one level interrupt.
 * Assumes rxd, tx_internal and prescaler_tick are synchronous to pclk;
 * prescaler_tick is a one-cycle pulse per serial prescaler output clock.
 */
// Decided for this implementation: the APB register port and the register addresses.
// Overview of operation
// - keep a 9-bit counter with one overflow bit and its control logic.
// - mode 00 idle, 01 bit time measurement, 10 arbitration, 11 unused.
// - mode 00 holds counter cleared and the arbiter idle.
// - lost flag is read-only, cleared by writing zero to upper mode bit.
// - clock select 1 counts at half prescaler rate, 0 at bus clock / 4.
// - done flag sets when measurement ends, any control write clears it.
// - overflow flag sets on counter overflow, any control write clears it.
// - counter msb readable in control register, cleared by control write.
// - count register shows low eight counter bits, cleared by control write.
// - running flag reads 1 while counting, 0 while stopped.
// - measure, select 0: start on rx falling edge, stop and finish on next.
// - measure, select 1: start while rx low, at once if already low.
// - measure, select 1: stop at next rx rising edge, giving break length.
// - arbitration: counter starts at every transmit output rising edge.
// - arbitration: sample rx at count 38h or 08h; low sets lost flag.
// - while lost flag is set the transmit pin is forced to 1.
// - transmit low before rx low seen resets counter until next rise.
`timescale 1ns/1ns
`include "arb_timer_defines.vh"

module serial_bus_arbiter_timer #(
    parameter ADDR_W = 8,
    parameter CNT_W = 9
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rxd,
    input wire tx_internal,
    input wire prescaler_tick,
    output wire txd_pin,
    output wire irq
);

    localparam SEL_NONE = 3'h0;
    localparam SEL_CTRL = 3'h1;
    localparam SEL_COUNT = 3'h2;
    localparam SEL_STAT = 3'h3;
    localparam SEL_MASK = 3'h4;

    function [2:0] reg_sel;
        input [ADDR_W-1:0] a;
        case (a)
            `OFS_CTRL: reg_sel = SEL_CTRL;
            `OFS_COUNT: reg_sel = SEL_COUNT;
            `OFS_IRQ_STATUS: reg_sel = SEL_STAT;
            `OFS_IRQ_MASK: reg_sel = SEL_MASK;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    reg [1:0] mode_r;
    reg clk_sel_r;
    reg lost_r;
    reg done_r;
    reg run_r;
    reg wrap_r;
    reg [CNT_W-1:0] count_r;
    reg [CNT_W-1:0] count_nxt;
    reg armed_r;
    reg rx_low_seen_r;
    reg rxd_d_r;
    reg tx_d_r;
    reg [1:0] div_r;
    reg half_r;
    reg [`IRQ_BITS-1:0] irq_stat_r;
    reg [`IRQ_BITS-1:0] irq_mask_r;
    reg [31:0] prdata_r;
    reg pslverr_r;

    wire access = psel && penable;
    wire wr = access && pwrite;
    wire [2:0] sel = reg_sel(paddr);
    wire wr_ctrl = wr && (sel == SEL_CTRL) && pstrb[0];
    wire wr_stat = wr && (sel == SEL_STAT) && pstrb[0];
    wire wr_mask = wr && (sel == SEL_MASK) && pstrb[0];

    wire [1:0] new_mode = {pwdata[`CTL_MODE_HI], pwdata[`CTL_MODE_LO]};
    wire mode_change = wr_ctrl && (new_mode != mode_r);

    wire rx_fall = rxd_d_r && !rxd;
    wire rx_rise = !rxd_d_r && rxd;
    wire tx_rise = !tx_d_r && tx_internal;
    wire tx_fall = tx_d_r && !tx_internal;

    wire measuring = (mode_r == `MODE_MEASURE);
    wire arbitrating = (mode_r == `MODE_ARBITRATE);

    // counter clock: slow bus division or half the prescaler rate
    wire tick = clk_sel_r ? (prescaler_tick && half_r) : (div_r == `BUS_DIV_LAST);

    wire [CNT_W-1:0] sample_at = clk_sel_r ? `SAMPLE_PRESC : `SAMPLE_BUS_DIV;
    wire at_sample = arbitrating && run_r && armed_r && (count_r == sample_at);

    wire [CNT_W:0] count_inc = {1'b0, count_r} + {{CNT_W{1'b0}}, 1'b1};
    wire count_step = run_r && tick;
    wire wrap_ev = count_step && count_inc[CNT_W];

    reg start_ev;
    reg stop_ev;
    reg done_ev;
    reg abort_ev;
    reg lost_ev;

    // start and stop decisions for the selected mode
    always @*
    begin
        start_ev = 1'b0;
        stop_ev = 1'b0;
        done_ev = 1'b0;
        abort_ev = 1'b0;
        lost_ev = 1'b0;
        case (mode_r)
            `MODE_MEASURE:
            begin
                if (!clk_sel_r)
                begin
                    if (!run_r && !done_r && rx_fall)
                        start_ev = 1'b1;
                    if (run_r && rx_fall)
                    begin
                        stop_ev = 1'b1;
                        done_ev = 1'b1;
                    end
                end
                else
                begin
                    // level test, so a line already low starts at once
                    if (!run_r && !done_r && !rxd)
                        start_ev = 1'b1;
                    if (run_r && rx_rise)
                    begin
                        stop_ev = 1'b1;
                        done_ev = 1'b1;
                    end
                end
            end
            `MODE_ARBITRATE:
            begin
                if (tx_rise)
                    start_ev = 1'b1;
                else if (run_r && tx_fall && !rx_low_seen_r)
                    abort_ev = 1'b1;
                if (at_sample && !rxd)
                    lost_ev = 1'b1;
            end
            default: start_ev = 1'b0;
        endcase
    end

    // control fields written by software
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= `RST_MODE;
            clk_sel_r <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            mode_r <= new_mode;
            clk_sel_r <= pwdata[`CTL_CLK_SEL];
        end
    end

    // edge detectors on the line inputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxd_d_r <= 1'b1;
            tx_d_r <= 1'b1;
        end
        else
        begin
            rxd_d_r <= rxd;
            tx_d_r <= tx_internal;
        end
    end

    // counter clock prescaling restarts with each run for a clean first period
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r <= 2'h0;
            half_r <= 1'b0;
        end
        else if (!run_r || start_ev)
        begin
            div_r <= 2'h0;
            half_r <= 1'b0;
        end
        else
        begin
            div_r <= div_r + 2'h1;
            if (prescaler_tick)
                half_r <= !half_r;
        end
    end

    // counter next value
    always @*
    begin
        count_nxt = count_r;
        if (mode_r == `MODE_IDLE || mode_r == `MODE_RESERVED)
            count_nxt = `RST_COUNT;
        else if (wr_ctrl || mode_change || abort_ev || start_ev)
            count_nxt = `RST_COUNT;
        else if (count_step)
            count_nxt = count_inc[CNT_W-1:0];
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= `RST_COUNT;
        else
            count_r <= count_nxt;
    end

    // running state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_r <= 1'b0;
        else if ((!measuring && !arbitrating) || mode_change)
            run_r <= 1'b0;
        else if (start_ev)
            run_r <= 1'b1;
        else if (stop_ev || abort_ev)
            run_r <= 1'b0;
    end

    // one sample per transmit rising edge; rx low history for abort test
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_r <= 1'b0;
            rx_low_seen_r <= 1'b0;
        end
        else if (!arbitrating || mode_change || abort_ev)
        begin
            armed_r <= 1'b0;
            rx_low_seen_r <= 1'b0;
        end
        else if (start_ev)
        begin
            armed_r <= 1'b1;
            rx_low_seen_r <= !rxd;
        end
        else
        begin
            if (at_sample)
                armed_r <= 1'b0;
            if (run_r && !rxd)
                rx_low_seen_r <= 1'b1;
        end
    end

    // status flags: a setting event wins over a clearing write
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lost_r <= 1'b0;
            done_r <= 1'b0;
            wrap_r <= 1'b0;
        end
        else
        begin
            if (lost_ev)
                lost_r <= 1'b1;
            else if (wr_ctrl && !pwdata[`CTL_MODE_HI])
                lost_r <= 1'b0;
            if (done_ev)
                done_r <= 1'b1;
            else if (wr_ctrl)
                done_r <= 1'b0;
            if (wrap_ev)
                wrap_r <= 1'b1;
            else if (wr_ctrl)
                wrap_r <= 1'b0;
        end
    end

    // interrupt: sticky status, write one to clear, set wins
    wire [`IRQ_BITS-1:0] irq_ev;
    wire [`IRQ_BITS-1:0] irq_stat_nxt;
    assign irq_ev[`IRQ_DONE] = done_ev;
    assign irq_ev[`IRQ_LOST] = lost_ev && !lost_r;
    assign irq_ev[`IRQ_WRAP] = wrap_ev;

    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_BITS; gi = gi + 1)
        begin : g_irq
            assign irq_stat_nxt[gi] = irq_ev[gi] || (irq_stat_r[gi] && !(wr_stat && pwdata[gi]));
        end
    endgenerate

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_r <= `RST_IRQ;
        else
            irq_stat_r <= irq_stat_nxt;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_r <= `RST_IRQ;
        else if (wr_mask)
            irq_mask_r <= pwdata[`IRQ_BITS-1:0];
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // seized line: recessive one driven out while arbitration is lost
    assign txd_pin = lost_r ? 1'b1 : tx_internal;

    wire [7:0] ctrl_rd = {mode_r, lost_r, clk_sel_r, done_r, run_r, wrap_r,
                          count_r[CNT_W-1]};

    // read data registered in the setup cycle; zero wait states
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_r <= (sel == SEL_NONE);
            case (sel)
                SEL_CTRL: prdata_r <= {24'h000000, ctrl_rd};
                SEL_COUNT: prdata_r <= {24'h000000, count_r[7:0]};
                SEL_STAT: prdata_r <= {29'h00000000, irq_stat_r};
                SEL_MASK: prdata_r <= {29'h00000000, irq_mask_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r && access;

endmodule

/* core/arb_timer_defines.vh */
/*
 * Register map, field positions, reset values, mode codes and counter
 * figures of the serial bus arbiter timer.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef ARB_TIMER_DEFINES_VH
`define ARB_TIMER_DEFINES_VH

// byte offsets on the APB bus
`define OFS_CTRL 8'h00
`define OFS_COUNT 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0C

// control/status register fields
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_LOST 5
`define CTL_CLK_SEL 4
`define CTL_DONE 3
`define CTL_RUN 2
`define CTL_WRAP 1
`define CTL_MSB 0

// interrupt status and mask fields
`define IRQ_DONE 0
`define IRQ_LOST 1
`define IRQ_WRAP 2
`define IRQ_BITS 3

// arbiter modes
`define MODE_IDLE 2'h0
`define MODE_MEASURE 2'h1
`define MODE_ARBITRATE 2'h2
`define MODE_RESERVED 2'h3

// reset values
`define RST_MODE 2'h0
`define RST_COUNT 9'h000
`define RST_IRQ 3'h0

// arbitration sample points, per counter clock select
`define SAMPLE_BUS_DIV 9'h038
`define SAMPLE_PRESC 9'h008

// bus clock divider for the slow counter clock
`define BUS_DIV 4
`define BUS_DIV_LAST 2'h3

`endif

/* verif/arb_timer_checker.sv */
/* Port checker for the serial bus arbiter timer.
   Assumes it is bound to the top module; sees its ports only. */
`timescale 1ns/1ns
module arb_timer_checker #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rxd,
    input wire tx_internal,
    input wire txd_pin,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    hole_read_a: assert property (psel && penable && !pwrite && paddr > 8'h0C
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    tx_pass_a: assert property (tx_internal |-> txd_pin)
        else $error("transmit pin low while transmit output high");
    force_cause_a: assert property (txd_pin && !tx_internal
        |-> $past(txd_pin) || !$past(rxd))
        else $error("pin forced without low receive sample");
    irq_clear_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("interrupt fell without a write");
    reset_clean_a: assert property ($rose(presetn) |-> !irq && txd_pin == tx_internal)
        else $error("state not clear after reset");
    cover property (txd_pin && !tx_internal);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule
bind serial_bus_arbiter_timer arb_timer_checker #(.ADDR_W(ADDR_W)) checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .tx_internal(tx_internal), .txd_pin(txd_pin), .irq(irq)
);

/* verif/bus_node_model.sv */
/* Other node on the shared single-wire bus.
   Assumes the bench commands when this node drives dominant. */
`timescale 1ns/1ns
module bus_node_model (
    input wire txd_pin,
    input wire dominant,
    output wire rxd
);
    // pulled up; any node driving low wins, so own low shows too
    assign rxd = txd_pin & ~dominant;
endmodule

/* verif/serial_bus_arbiter_timer_tb.sv */
/* Self-checking bench for the serial bus arbiter timer.
   Assumes the checker is bound; bench is the APB master. */
`timescale 1ns/1ns
module serial_bus_arbiter_timer_tb;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic tx_int = 1;
    logic tick = 0;
    logic node_low = 0;
    logic [1:0] ph = 0;
    logic [31:0] q;
    logic err;
    wire [31:0] prdata;
    wire pready, pslverr, rxd, txd_pin, irq;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    serial_bus_arbiter_timer serial_bus_arbiter_timer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .tx_internal(tx_int), .prescaler_tick(tick),
        .txd_pin(txd_pin), .irq(irq)
    );
    bus_node_model bus_node_model_i (.txd_pin(txd_pin), .dominant(node_low), .rxd(rxd));
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        ph <= ph + 2'h1;
        tick <= (ph == 2'h3);
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            failures++;
            complete_run;
        end
    end
    task complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(0, a, 0);
        chk(q & m, e);
    endtask
    // second low edge ends the run; counter steps every 4th cycle
    task automatic measure(input int n, input logic [31:0] ectl, input logic [31:0] ecnt);
        apb(1, 8'h00, 32'h40);
        node_low <= 1;
        repeat (n / 2) @(posedge pclk);
        node_low <= 0;
        repeat (n - n / 2) @(posedge pclk);
        node_low <= 1;
        repeat (3) @(posedge pclk);
        node_low <= 0;
        rd(8'h00, 32'hFF, ectl);
        rd(8'h04, 32'hFF, ecnt);
        rd(8'h08, 32'h1, 32'h1);
        $display("measure %0d done", n);
    endtask
    task break_len;
        node_low <= 1;
        apb(1, 8'h00, 32'h50);
        rd(8'h00, 32'hFF, 32'h54);
        rd(8'h00, 32'h03, 0);
        repeat (48) @(posedge pclk);
        node_low <= 0;
        repeat (3) @(posedge pclk);
        rd(8'h00, 32'hFF, 32'h58);
        apb(0, 8'h04, 0);
        chk({31'h0, q >= 5 && q <= 7}, 32'h1);
        $display("break_len done");
    endtask
    task arb_lost;
        apb(1, 8'h0C, 32'h2);
        apb(1, 8'h00, 32'h80);
        tx_int <= 0;
        @(posedge pclk);
        tx_int <= 1;
        node_low <= 1;
        repeat (210) @(posedge pclk);
        rd(8'h00, 32'h20, 0);
        repeat (20) @(posedge pclk);
        rd(8'h00, 32'h20, 32'h20);
        tx_int <= 0;
        @(posedge pclk);
        chk(txd_pin, 1);
        chk(irq, 1);
        apb(1, 8'h0C, 0);
        #1 chk(irq, 0);
        apb(1, 8'h0C, 32'h2);
        #1 chk(irq, 1);
        apb(1, 8'h08, 32'h2);
        #1 chk(irq, 0);
        apb(1, 8'h00, 32'h80);
        rd(8'h00, 32'h20, 32'h20);
        apb(1, 8'h00, 0);
        rd(8'h00, 32'h20, 0);
        chk(txd_pin, 0);
        tx_int <= 1;
        node_low <= 0;
        $display("arb_lost done");
    endtask
    task arb_fall;
        apb(1, 8'h00, 32'h80);
        tx_int <= 0;
        @(posedge pclk);
        tx_int <= 1;
        repeat (40) @(posedge pclk);
        rd(8'h00, 32'h04, 32'h04);
        tx_int <= 0;
        repeat (3) @(posedge pclk);
        rd(8'h04, 32'hFF, 0);
        rd(8'h00, 32'h24, 0);
        tx_int <= 1;
        $display("arb_fall done");
    endtask
    task refused;
        apb(0, 8'h10, 0);
        chk(err, 1);
        chk(q, 0);
        apb(1, 8'h00, 0);
        apb(1, 8'h04, 32'hFF);
        node_low <= 1;
        repeat (20) @(posedge pclk);
        node_low <= 0;
        rd(8'h04, 32'hFF, 0);
        rd(8'h00, 32'hFF, 0);
        // reserved mode must behave as idle
        apb(1, 8'h00, 32'hC0);
        node_low <= 1;
        repeat (20) @(posedge pclk);
        node_low <= 0;
        rd(8'h04, 32'hFF, 0);
        rd(8'h00, 32'h07, 0);
        $display("refused done");
    endtask
    // sample point at count 08h when counting on the prescaler
    task arb_presc;
        apb(1, 8'h00, 32'h90);
        tx_int <= 0;
        @(posedge pclk);
        tx_int <= 1;
        node_low <= 1;
        repeat (40) @(posedge pclk);
        rd(8'h00, 32'h20, 0);
        repeat (60) @(posedge pclk);
        rd(8'h00, 32'h20, 32'h20);
        apb(1, 8'h00, 0);
        node_low <= 0;
        $display("arb_presc done");
    endtask
    task automatic reset_values;
        for (int a = 0; a < 16; a += 4)
            rd(a[7:0], 32'hFFFFFFFF, 0);
        $display("reset_values done");
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        reset_values;
        measure(42, 32'h48, 32'h0A);
        measure(1026, 32'h49, 0);
        measure(2054, 32'h4A, 32'h01);
        break_len;
        arb_lost;
        arb_fall;
        arb_presc;
        refused;
        complete_run;
    end
endmodule
